// File: ccc_addr_gen.v
// Purpose: operand address forming for register-operand instructions
// Assumes: 12-bit data address, 4-bit bank select
// Notes: combinational
`timescale 1ns/1ps
`include "ccc_defines.vh"
module ccc_addr_gen (
    input wire [7:0] field,        // register field of the opcode
    input wire access_bit,         // access/bank selector
    input wire ext_set_en,         // extended instruction set enabled
    input wire [3:0] bank_sel,     // bank select register value
    input wire [11:0] index_base,  // index register for literal offset
    output reg [11:0] addr         // resulting data address
);
    always @* begin
        if (!access_bit && ext_set_en && field <= `IDX_LIMIT) begin
            addr = index_base + {4'h0, field};
        end else if (!access_bit) begin
            // access bank: low half to bank 0, upper half to the top bank
            addr = field[7] ? {4'hf, field} : {4'h0, field};
        end else begin
            addr = {bank_sel, field};
        end
    end
endmodule

// File: ccc_core.v
// Purpose: decode and execute clear, watchdog-clear, complement, compare-skip
// Assumes: one instruction word presented per four-phase cycle
// Notes: data memory is external and read combinationally via rd_addr
`timescale 1ns/1ps
`include "ccc_defines.vh"
module ccc_core (
    input wire sys_clk,            // instruction clock
    input wire rst_n,              // asynchronous reset, active low
    input wire instr_valid,        // new instruction word offered
    input wire [15:0] instr,       // instruction word
    input wire ext_set_en,         // extended instruction set enabled
    input wire [3:0] bank_sel,     // bank select register value
    input wire [11:0] index_base,  // index base for literal offset mode
    input wire [7:0] wreg_in,      // working register value
    input wire [7:0] rd_data,      // data read from memory
    output wire instr_ready,       // block accepts a word in decode phase
    output wire [11:0] rd_addr,    // data memory read address
    output wire mem_we,            // data memory write strobe
    output wire [11:0] mem_waddr,  // data memory write address
    output wire [7:0] mem_wdata,   // data memory write data
    output wire wreg_we,           // working register write strobe
    output wire [7:0] wreg_wdata,  // working register write data
    output wire zero_flag,         // status zero
    output wire neg_flag,          // status negative
    output wire timeout_flag_n,    // status time-out, active low
    output wire powerdown_flag_n,  // status power-down, active low
    output wire watchdog_clr,      // watchdog counter and postscaler reset
    output wire [7:0] watchdog_counter, // watchdog counter
    output wire skip_active        // discarded instruction cycle running
);
    // *******************************
    // decode
    // *******************************
    localparam OP_NONE = 3'h0;
    localparam OP_CLR = 3'h1;
    localparam OP_WCLR = 3'h2;
    localparam OP_COM = 3'h3;
    localparam OP_CPS = 3'h4;

    reg [1:0] phase_reg;
    reg [1:0] phase_next;
    reg [2:0] op_reg;
    reg [2:0] op_next;
    reg [15:0] ir_reg;
    reg skip_pending_reg;
    reg [7:0] result_reg;
    reg equal_reg;
    reg instr_ready_reg;
    reg [11:0] rd_addr_reg;
    reg mem_we_reg;
    reg [11:0] mem_waddr_reg;
    reg [7:0] mem_wdata_reg;
    reg wreg_we_reg;
    reg [7:0] wreg_wdata_reg;
    reg zero_flag_reg;
    reg neg_flag_reg;
    reg timeout_flag_n_reg;
    reg powerdown_flag_n_reg;
    reg watchdog_clr_reg;
    reg [7:0] watchdog_counter_reg;
    reg skip_active_reg;
    wire [11:0] addr;
    wire take_word;
    wire wd_clear_now;

    // *******************************
    // outputs
    // *******************************
    assign instr_ready = instr_ready_reg;
    assign rd_addr = rd_addr_reg;
    assign mem_we = mem_we_reg;
    assign mem_waddr = mem_waddr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign wreg_we = wreg_we_reg;
    assign wreg_wdata = wreg_wdata_reg;
    assign zero_flag = zero_flag_reg;
    assign neg_flag = neg_flag_reg;
    assign timeout_flag_n = timeout_flag_n_reg;
    assign powerdown_flag_n = powerdown_flag_n_reg;
    assign watchdog_clr = watchdog_clr_reg;
    assign watchdog_counter = watchdog_counter_reg;
    assign skip_active = skip_active_reg;

    assign take_word = (phase_reg == `PH_DECODE) && instr_valid;
    assign wd_clear_now = (phase_reg == `PH_PROC) && (op_reg == OP_WCLR);

    always @* begin
        if (instr == `OP_WDCLR_WORD) begin
            op_next = OP_WCLR;
        end else if (instr[15:9] == `OP_CLR_HI) begin
            op_next = OP_CLR;
        end else if (instr[15:10] == `OP_COM_HI) begin
            op_next = OP_COM;
        end else if (instr[15:9] == `OP_CPSEQ_HI) begin
            op_next = OP_CPS;
        end else begin
            op_next = OP_NONE;
        end
    end

    ccc_addr_gen u_addr (
        .field(ir_reg[7:0]),
        .access_bit(ir_reg[`BIT_ACCESS]),
        .ext_set_en(ext_set_en),
        .bank_sel(bank_sel),
        .index_base(index_base),
        .addr(addr)
    );

    // *******************************
    // four-phase sequencer
    // *******************************
    always @* begin
        case (phase_reg)
            `PH_DECODE: begin
                phase_next = take_word ? `PH_READ : `PH_DECODE;
            end
            `PH_READ: phase_next = `PH_PROC;
            `PH_PROC: phase_next = `PH_WRITE;
            `PH_WRITE: phase_next = `PH_DECODE;
            default: phase_next = `PH_DECODE;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= `PH_DECODE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // *******************************
    // watchdog counter
    // *******************************
    // free count; the clear pulse also resets the postscaler outside
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_counter_reg <= 8'h00;
            watchdog_clr_reg <= 1'b0;
            timeout_flag_n_reg <= 1'b1;
            powerdown_flag_n_reg <= 1'b1;
        end else begin
            watchdog_clr_reg <= wd_clear_now;
            if (wd_clear_now) begin
                watchdog_counter_reg <= 8'h00;
                timeout_flag_n_reg <= 1'b1;
                powerdown_flag_n_reg <= 1'b1;
            end else begin
                watchdog_counter_reg <= watchdog_counter_reg + 8'h01;
            end
        end
    end

    // *******************************
    // operand, result and write-back
    // *******************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_reg <= OP_NONE;
            ir_reg <= 16'h0000;
            skip_pending_reg <= 1'b0;
            result_reg <= 8'h00;
            equal_reg <= 1'b0;
            instr_ready_reg <= 1'b1;
            rd_addr_reg <= 12'h000;
            mem_we_reg <= 1'b0;
            mem_waddr_reg <= 12'h000;
            mem_wdata_reg <= 8'h00;
            wreg_we_reg <= 1'b0;
            wreg_wdata_reg <= 8'h00;
            zero_flag_reg <= 1'b0;
            neg_flag_reg <= 1'b0;
            skip_active_reg <= 1'b0;
        end else begin
            mem_we_reg <= 1'b0;
            wreg_we_reg <= 1'b0;
            case (phase_reg)
                `PH_DECODE: begin
                    if (take_word) begin
                        ir_reg <= instr;
                        // the word fetched behind a taken skip runs as nop
                        if (skip_pending_reg) begin
                            op_reg <= OP_NONE;
                        end else begin
                            op_reg <= op_next;
                        end
                        skip_active_reg <= skip_pending_reg;
                        skip_pending_reg <= 1'b0;
                        instr_ready_reg <= 1'b0;
                    end
                end
                `PH_READ: begin
                    rd_addr_reg <= addr;
                    mem_waddr_reg <= addr;
                end
                `PH_PROC: begin
                    case (op_reg)
                        OP_CLR: result_reg <= 8'h00;
                        OP_COM: result_reg <= ~rd_data;
                        OP_CPS: begin
                            // difference only judged, never stored
                            equal_reg <= (rd_data - wreg_in) == 8'h00;
                        end
                        default: result_reg <= result_reg;
                    endcase
                end
                `PH_WRITE: begin
                    case (op_reg)
                        OP_CLR: begin
                            mem_we_reg <= 1'b1;
                            mem_wdata_reg <= 8'h00;
                            zero_flag_reg <= 1'b1;
                        end
                        OP_COM: begin
                            if (ir_reg[`BIT_DEST]) begin
                                mem_we_reg <= 1'b1;
                                mem_wdata_reg <= result_reg;
                            end else begin
                                wreg_we_reg <= 1'b1;
                                wreg_wdata_reg <= result_reg;
                            end
                            zero_flag_reg <= (result_reg == 8'h00);
                            neg_flag_reg <= result_reg[7];
                        end
                        OP_CPS: skip_pending_reg <= equal_reg;
                        default: skip_pending_reg <= 1'b0;
                    endcase
                    instr_ready_reg <= 1'b1;
                end
                default: ir_reg <= ir_reg;
            endcase
        end
    end
endmodule

// File: ccc_core_props.sv
// Purpose: timing and result properties of ccc_core
// Assumes: handshake and latencies as handed over
// Notes: bound into every ccc_core
`timescale 1ns/1ps
module ccc_core_chk (
    input wire sys_clk, // clock
    input wire rst_n, // reset
    input wire instr_valid, // offer
    input wire [15:0] instr, // word
    input wire ext_set_en, // ext set
    input wire [3:0] bank_sel, // bank
    input wire [11:0] index_base, // base
    input wire [7:0] wreg_in, // w
    input wire [7:0] rd_data, // operand
    input wire instr_ready, // ready
    input wire [11:0] rd_addr, // address
    input wire mem_we, // write
    input wire [7:0] mem_wdata, // data
    input wire wreg_we, // w write
    input wire zero_flag, // z
    input wire neg_flag, // n
    input wire timeout_flag_n, // to
    input wire powerdown_flag_n, // pd
    input wire watchdog_clr, // clear pulse
    input wire [7:0] watchdog_counter, // counter
    input wire skip_active // nop cycle
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire live = instr_valid && instr_ready;
    wire [7:0] f = instr[7:0];
    wire clr = instr[15:9] == 7'h35;
    wire com = instr[15:10] == 6'h07;
    wire cmp = instr[15:9] == 7'h31;
    wire wd_op = instr == 16'h0004;
    wire rop = clr || com || cmp;
    sequence go(c);
        live && c ##1 !skip_active;
    endsequence
    a_ready_idle: assert property (
        instr_valid && instr_ready |=> !instr_ready [*3] ##1 instr_ready)
        else $error("ready timing wrong");
    a_clear_zero: assert property (
        go(clr) |-> ##3 mem_we && mem_wdata == 8'h00 && zero_flag)
        else $error("clear result wrong");
    a_wdclr_pulse: assert property (
        go(wd_op) |-> ##2 watchdog_clr && watchdog_counter == 8'h00
        ##1 !watchdog_clr)
        else $error("watchdog clear wrong");
    a_status_set: assert property (
        go(wd_op) |-> ##2 timeout_flag_n && powerdown_flag_n ##1
        zero_flag == $past(zero_flag, 3) && neg_flag == $past(neg_flag, 3))
        else $error("watchdog status wrong");
    a_cmp_quiet: assert property (
        go(cmp) |-> ##3 !mem_we && !wreg_we &&
        zero_flag == $past(zero_flag, 3) && neg_flag == $past(neg_flag, 3))
        else $error("compare not quiet");
    a_com_dest: assert property (
        go(com) |-> ##3 ($past(instr[9], 4) ? mem_we && !wreg_we
        : wreg_we && !mem_we))
        else $error("complement destination wrong");
    a_bank_addr: assert property (
        go(rop && instr[8]) |-> ##1
        rd_addr == {$past(bank_sel, 2), $past(f, 2)})
        else $error("bank address wrong");
    a_access_addr: assert property (
        go(rop && !instr[8] && !ext_set_en) |-> ##1
        rd_addr == {{4{$past(f[7], 2)}}, $past(f, 2)})
        else $error("access address wrong");
    a_indexed_addr: assert property (
        go(rop && !instr[8] && ext_set_en && f <= 8'h5f) |-> ##1
        rd_addr == $past(index_base, 2) + {4'h0, $past(f, 2)})
        else $error("indexed address wrong");
    a_skip_nop: assert property (
        go(cmp) ##1 (rd_data == wreg_in) |-> ##6 !mem_we && !wreg_we)
        else $error("skipped word not discarded");
    a_nop_quiet: assert property (
        $rose(skip_active) |-> ##3 !mem_we && !wreg_we)
        else $error("nop cycle wrote");
endmodule
bind ccc_core ccc_core_chk u_chk (.*);

// File: ccc_defines.vh
// Purpose: constants for the clear/complement/compare instruction block
// Assumes: 16-bit instruction words, 8-bit data path
// Notes: included by both design files
`ifndef CCC_DEFINES_VH
`define CCC_DEFINES_VH
// *******************************
// opcodes
// *******************************
`define OP_WDCLR_WORD 16'h0004
`define BIT_ACCESS 8
`define BIT_DEST 9
`define OP_CLR_HI 7'h35
`define OP_COM_HI 6'h07
`define OP_CPSEQ_HI 7'h31
`define IDX_LIMIT 8'h5f
// *******************************
// phases
// *******************************
`define PH_DECODE 2'h0
`define PH_READ 2'h1
`define PH_PROC 2'h2
`define PH_WRITE 2'h3
`endif

// File: tb.sv
// Purpose: directed bench for ccc_core
// Assumes: operand data held by the bench per instruction
// Notes: results judged after the write phase, the watchdog clear during it
`timescale 1ns/1ps
module tb;
    reg sys_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0;
    reg [15:0] instr = 16'h0000;
    reg [3:0] bank_sel = 4'h0;
    reg [11:0] index_base = 12'h000;
    reg [7:0] wreg_in = 8'h00, rd_data = 8'h00;
    wire instr_ready, mem_we, wreg_we, zero_flag, neg_flag, watchdog_clr;
    wire timeout_flag_n, powerdown_flag_n, skip_active;
    wire [11:0] rd_addr, mem_waddr;
    wire [7:0] mem_wdata, wreg_wdata, watchdog_counter;
    integer fail_count = 0, n_compared = 0;
    ccc_core u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr(instr), .ext_set_en(ext_set_en),
        .bank_sel(bank_sel), .index_base(index_base), .wreg_in(wreg_in),
        .rd_data(rd_data), .instr_ready(instr_ready), .rd_addr(rd_addr),
        .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
        .wreg_we(wreg_we), .wreg_wdata(wreg_wdata), .zero_flag(zero_flag),
        .neg_flag(neg_flag), .timeout_flag_n(timeout_flag_n),
        .powerdown_flag_n(powerdown_flag_n), .watchdog_clr(watchdog_clr),
        .watchdog_counter(watchdog_counter), .skip_active(skip_active));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task conclude;
        begin
            if (fail_count == 0 && n_compared > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [11:0] got, input [11:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // offer a word and return on the edge that takes it
    task issue(input [15:0] w);
        integer i;
        begin
            @(posedge sys_clk);
            instr <= w;
            instr_valid <= 1'b1;
            i = 0;
            @(negedge sys_clk);
            while (instr_ready !== 1'b1 && i < 20) begin
                @(negedge sys_clk);
                i = i + 1;
            end
            if (instr_ready !== 1'b1) begin
                fail_count = fail_count + 1;
                conclude;
            end else begin
                @(posedge sys_clk);
                instr_valid <= 1'b0;
            end
        end
    endtask
    task res;
        begin
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
        end
    endtask
    task t_clear;
        begin
            @(posedge sys_clk);
            rd_data <= 8'h5a;
            bank_sel <= 4'h3;
            issue(16'h6b10);
            res;
            chk(mem_we, 12'h001);
            chk(mem_waddr, 12'h310);
            chk(mem_wdata, 12'h000);
            chk(zero_flag, 12'h001);
            chk(instr_ready, 12'h001);
        end
    endtask
    task t_com;
        begin
            @(posedge sys_clk);
            rd_data <= 8'hf0;
            ext_set_en <= 1'b1;
            index_base <= 12'h200;
            issue(16'h1e05);
            res;
            chk(mem_we, 12'h001);
            chk(mem_waddr, 12'h205);
            chk(mem_wdata, 12'h00f);
            chk({zero_flag, neg_flag}, 12'h000);
            @(posedge sys_clk);
            rd_data <= 8'h13;
            issue(16'h1c20);
            res;
            chk(wreg_we, 12'h001);
            chk(mem_we, 12'h000);
            chk(wreg_wdata, 12'h0ec);
            chk(rd_addr, 12'h220);
            chk({zero_flag, neg_flag}, 12'h001);
        end
    endtask
    task t_wd;
        begin
            @(posedge sys_clk);
            ext_set_en <= 1'b0;
            issue(16'h0004);
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk(watchdog_clr, 12'h001);
            chk(watchdog_counter, 12'h000);
            chk({timeout_flag_n, powerdown_flag_n}, 12'h003);
            chk({zero_flag, neg_flag}, 12'h001);
        end
    endtask
    // equal compare then a clear back to back, then the unequal case
    task t_skip(input [7:0] d, input [11:0] fl, input [11:0] we,
        input [11:0] sk);
        begin
            @(posedge sys_clk);
            rd_data <= d;
            wreg_in <= 8'h5a;
            issue(16'h6210);
            issue(16'h6a90);
            res;
            chk(mem_we, we);
            chk(skip_active, sk);
            chk({zero_flag, neg_flag}, fl);
        end
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_clear;
        t_com;
        t_wd;
        t_skip(8'h5a, 12'h001, 12'h000, 12'h001);
        t_skip(8'h5b, 12'h003, 12'h001, 12'h000);
        chk(mem_waddr, 12'hf90);
        conclude;
    end
endmodule
